// [rtl/smfc_pkg.sv]
// Shared constants and types of the serial master queue controller
package smfc_pkg;

   // Serial timing
   localparam int SMFC_MIN_PERIOD = 5;
   localparam int SMFC_DEF_PERIOD = 5;
   localparam int SMFC_TIMER_W = 16;
   localparam int SMFC_BITS = 8;
   localparam logic [4:0] SMFC_LAST_EDGE = 5'h10;

   // Queue defaults
   localparam int SMFC_DEF_DEPTH = 8;
   localparam int SMFC_DEF_DEPTH_BITS = 3;

   // Select lines
   localparam int SMFC_SLAVES = 16;
   localparam logic [15:0] SMFC_SEL_IDLE = 16'hffff;
   localparam logic [15:0] SMFC_SEL_ONE = 16'h0001;

   // Miso synchroniser reset level
   localparam logic [2:0] SMFC_SYNC_RST = 3'h0;

   // Instruction codes
   typedef enum logic [1:0] {
      SMFC_WRITE  = 2'b00,
      SMFC_READ   = 2'b01,
      SMFC_DUPLEX = 2'b10,
      SMFC_DUMMY  = 2'b11
   } smfc_inst_e;

   // Command and response word
   typedef struct packed {
      logic [3:0] sel;
      smfc_inst_e inst;
      logic [7:0] data;
   } smfc_cmd_s;

   localparam int SMFC_CMD_W = $bits(smfc_cmd_s);

endpackage

// [rtl/smfc_sync.sv]
// Three-stage input synchroniser with agreement filter
module smfc_sync
   import smfc_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Asynchronous input and filtered level
   input wire logic async_i,
   output logic level_o
);

   typedef struct packed {
      logic [2:0] stage;
      logic level;
   } smfc_sync_s;

   smfc_sync_s s_ff;
   smfc_sync_s nxt_s;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.stage = {s_ff.stage[1:0], async_i};
      // Change counts once second and third stage agree
      if (s_ff.stage[1] == s_ff.stage[2]) begin
         nxt_s.level = s_ff.stage[2];
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_ff <= '{stage: SMFC_SYNC_RST, level: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign level_o = s_ff.level;

endmodule // smfc_sync

// [rtl/smfc_fifo.sv]
// Parameterised queue with valid/ready on both sides
module smfc_fifo
   import smfc_pkg::*;
#(
   parameter int WIDTH = SMFC_CMD_W,
   parameter int DEPTH = SMFC_DEF_DEPTH,
   parameter int DEPTH_BITS = SMFC_DEF_DEPTH_BITS
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Fill side
   input wire logic allow_i,
   input wire logic wr_valid_i,
   input wire logic [WIDTH-1:0] wr_data_i,
   output logic wr_ready_o,
   output logic room_o,
   // Drain side
   output logic rd_valid_o,
   output logic [WIDTH-1:0] rd_data_o,
   input wire logic rd_ready_i
);

   localparam logic [DEPTH_BITS:0] FULL = (DEPTH_BITS + 1)'(DEPTH);
   localparam logic [DEPTH_BITS-1:0] LAST = DEPTH_BITS'(DEPTH - 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0] head;
      logic [DEPTH_BITS-1:0] wr_ptr;
      logic [DEPTH_BITS-1:0] rd_ptr;
      logic [DEPTH_BITS:0] count;
      logic ready;
      logic valid;
   } smfc_fifo_s;

   smfc_fifo_s s_ff;
   smfc_fifo_s nxt_s;
   logic push;
   logic pop;

   always_comb begin
      nxt_s = s_ff;
      push = wr_valid_i & s_ff.ready;
      pop = s_ff.valid & rd_ready_i;
      if (push) begin
         nxt_s.mem[s_ff.wr_ptr] = wr_data_i;
         nxt_s.wr_ptr = (s_ff.wr_ptr == LAST) ? '0 : s_ff.wr_ptr + 1'b1;
      end
      if (pop) begin
         nxt_s.rd_ptr = (s_ff.rd_ptr == LAST) ? '0 : s_ff.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         nxt_s.count = s_ff.count + 1'b1;
      end else if (pop && !push) begin
         nxt_s.count = s_ff.count - 1'b1;
      end
      nxt_s.valid = (nxt_s.count != '0);
      nxt_s.ready = (nxt_s.count != FULL) & allow_i;
      room_o = (nxt_s.count != FULL);
      // Head word registered so the drain side reads straight from a flop
      nxt_s.head = nxt_s.mem[nxt_s.rd_ptr];
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign wr_ready_o = s_ff.ready;
   assign rd_valid_o = s_ff.valid;
   assign rd_data_o = s_ff.head;

endmodule // smfc_fifo

// [rtl/smfc_top.sv]
// Serial master controller with command and response queues
module smfc_top
   import smfc_pkg::*;
#(
   parameter int T_PERIOD = SMFC_DEF_PERIOD,
   parameter int CPOL = 0,
   parameter int CPHA = 0,
   parameter int CMD_DEPTH = SMFC_DEF_DEPTH,
   parameter int cmd_queue_depth_bits = SMFC_DEF_DEPTH_BITS,
   parameter int RESP_DEPTH = SMFC_DEF_DEPTH,
   parameter int resp_queue_depth_bits = SMFC_DEF_DEPTH_BITS
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Command port
   input wire logic [3:0] cmd_sel_i,
   input wire logic [1:0] cmd_inst_i,
   input wire logic [7:0] cmd_data_i,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   // Serial bus
   output logic sclk_o,
   output logic [15:0] sel_n_o,
   output logic mosi_o,
   input wire logic miso_i,
   // Response port
   output logic [3:0] resp_sel_o,
   output logic [1:0] resp_inst_o,
   output logic [7:0] resp_data_o,
   output logic resp_valid_o,
   input wire logic resp_ready_i
);

   // Period clamped to the legal minimum, split into two half periods
   localparam int T_EFF = (T_PERIOD < SMFC_MIN_PERIOD) ? SMFC_MIN_PERIOD : T_PERIOD;
   localparam logic [SMFC_TIMER_W-1:0] HALF_A = SMFC_TIMER_W'(T_EFF / 2 - 1);
   localparam logic [SMFC_TIMER_W-1:0] HALF_B = SMFC_TIMER_W'(T_EFF - T_EFF / 2 - 1);
   localparam logic IDLE_CLK = (CPOL != 0);
   localparam logic PHASE = (CPHA != 0);

   typedef enum logic [1:0] {
      SMFC_IDLE  = 2'b00,
      SMFC_SHIFT = 2'b01,
      SMFC_HOLD  = 2'b10
   } smfc_state_e;

   typedef struct packed {
      smfc_state_e st;
      logic [15:0] sel_n;
      logic sclk;
      logic mosi;
      logic [7:0] tx;
      logic [7:0] rx;
      smfc_cmd_s cur;
      logic [4:0] edge_cnt;
      logic [SMFC_TIMER_W-1:0] timer;
   } smfc_ctl_s;

   smfc_ctl_s s_ff;
   smfc_ctl_s nxt_s;

   smfc_cmd_s cmd_in;
   smfc_cmd_s cmd_head;
   smfc_cmd_s resp_word;
   smfc_cmd_s resp_head;
   logic [SMFC_CMD_W-1:0] cmd_head_bits;
   logic [SMFC_CMD_W-1:0] resp_head_bits;
   logic cmd_head_valid;
   logic cmd_pop;
   logic resp_push;
   logic resp_ready;
   logic resp_room;
   logic miso_lvl;
   logic [4:0] nxt_edge;
   logic sample_edge;

   assign cmd_in = '{sel: cmd_sel_i, inst: smfc_inst_e'(cmd_inst_i), data: cmd_data_i};
   assign cmd_head = smfc_cmd_s'(cmd_head_bits);
   assign resp_head = smfc_cmd_s'(resp_head_bits);

   // Input queue; its ready also waits on room in the response queue
   smfc_fifo #(
      .WIDTH(SMFC_CMD_W),
      .DEPTH(CMD_DEPTH),
      .DEPTH_BITS(cmd_queue_depth_bits)
   ) u_cmd_queue (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .allow_i(resp_room),
      .wr_valid_i(cmd_valid_i),
      .wr_data_i(cmd_in),
      .wr_ready_o(cmd_ready_o),
      .room_o(),
      .rd_valid_o(cmd_head_valid),
      .rd_data_o(cmd_head_bits),
      .rd_ready_i(cmd_pop)
   );

   // Response queue
   smfc_fifo #(
      .WIDTH(SMFC_CMD_W),
      .DEPTH(RESP_DEPTH),
      .DEPTH_BITS(resp_queue_depth_bits)
   ) u_resp_queue (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .allow_i(1'b1),
      .wr_valid_i(resp_push),
      .wr_data_i(resp_word),
      .wr_ready_o(resp_ready),
      .room_o(resp_room),
      .rd_valid_o(resp_valid_o),
      .rd_data_o(resp_head_bits),
      .rd_ready_i(resp_ready_i)
   );

   // Miso synchroniser
   smfc_sync u_miso_sync (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .async_i(miso_i),
      .level_o(miso_lvl)
   );

   always_comb begin
      nxt_s = s_ff;
      cmd_pop = 1'b0;
      resp_push = 1'b0;
      resp_word = s_ff.cur;
      nxt_edge = s_ff.edge_cnt + 5'h01;
      sample_edge = nxt_edge[0] ^ PHASE;
      unique case (s_ff.st)
         SMFC_IDLE: begin
            nxt_s.sclk = IDLE_CLK;
            if (cmd_head_valid) begin
               if (cmd_head.inst == SMFC_DUMMY) begin
                  cmd_pop = 1'b1;
                  nxt_s.sel_n = SMFC_SEL_IDLE;
               end else if (resp_ready) begin
                  // Start of a byte: select, first data bit, half period lead
                  cmd_pop = 1'b1;
                  nxt_s.cur = cmd_head;
                  nxt_s.sel_n = ~(SMFC_SEL_ONE << cmd_head.sel);
                  nxt_s.tx = (cmd_head.inst == SMFC_READ) ? 8'h00 : cmd_head.data;
                  nxt_s.mosi = (cmd_head.inst == SMFC_READ) ? 1'b0 : cmd_head.data[7];
                  nxt_s.rx = 8'h00;
                  nxt_s.edge_cnt = 5'h00;
                  nxt_s.timer = HALF_A;
                  nxt_s.st = SMFC_SHIFT;
               end
            end
         end
         SMFC_SHIFT: begin
            if (s_ff.timer != '0) begin
               nxt_s.timer = s_ff.timer - 1'b1;
            end else begin
               nxt_s.sclk = ~s_ff.sclk;
               nxt_s.edge_cnt = nxt_edge;
               nxt_s.timer = nxt_edge[0] ? HALF_B : HALF_A;
               if (sample_edge) begin
                  nxt_s.rx = {s_ff.rx[6:0], miso_lvl};
               end else if (nxt_edge != SMFC_LAST_EDGE) begin
                  nxt_s.mosi = PHASE ? s_ff.tx[7] : s_ff.tx[6];
                  nxt_s.tx = {s_ff.tx[6:0], 1'b0};
               end
               if (nxt_edge == SMFC_LAST_EDGE) begin
                  nxt_s.timer = HALF_A;
                  nxt_s.st = SMFC_HOLD;
               end
            end
         end
         SMFC_HOLD: begin
            if (s_ff.timer != '0) begin
               nxt_s.timer = s_ff.timer - 1'b1;
            end else begin
               // Echo the command; writes carry the supplied byte back
               resp_push = 1'b1;
               if (s_ff.cur.inst != SMFC_WRITE) begin
                  resp_word.data = s_ff.rx;
               end
               nxt_s.st = SMFC_IDLE;
            end
         end
         default: begin
            nxt_s.st = SMFC_IDLE;
            nxt_s.sel_n = SMFC_SEL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_ff <= '{st: SMFC_IDLE, sel_n: SMFC_SEL_IDLE, sclk: IDLE_CLK,
                   mosi: 1'b0, tx: 8'h00, rx: 8'h00, cur: '0, edge_cnt: 5'h00, timer: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign sclk_o = s_ff.sclk;
   assign sel_n_o = s_ff.sel_n;
   assign mosi_o = s_ff.mosi;
   assign resp_sel_o = resp_head.sel;
   assign resp_inst_o = resp_head.inst;
   assign resp_data_o = resp_head.data;

endmodule // smfc_top

// [test/smfc_sva.sv]
// Assertion checker on the serial master controller ports
module smfc_sva
   import smfc_pkg::*;
#(
   parameter int T_PERIOD = 5,
   parameter int CPOL = 0,
   parameter int CPHA = 0
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Serial bus
   input wire logic sclk_o,
   input wire logic [15:0] sel_n_o,
   input wire logic mosi_o,
   // Response port
   input wire logic [3:0] resp_sel_o,
   input wire logic [1:0] resp_inst_o,
   input wire logic [7:0] resp_data_o,
   input wire logic resp_valid_o,
   input wire logic resp_ready_i
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF = T_PERIOD / 2;
   logic sclk_q_ff;
   logic [7:0] run_ff;
   logic [7:0] sel_run_ff;
   // Cycles since the last serial clock change and since select went low
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_q_ff <= CPOL[0];
         run_ff <= 8'hff;
         sel_run_ff <= 8'h00;
      end else begin
         sclk_q_ff <= sclk_o;
         run_ff <= (sclk_o != sclk_q_ff) ? 8'h00 : run_ff + {7'h00, run_ff != 8'hff};
         sel_run_ff <= (&sel_n_o) ? 8'h00 : sel_run_ff + {7'h00, sel_run_ff != 8'hff};
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_edge;
      sclk_o != sclk_q_ff;
   endsequence
   sequence s_sample;
      s_edge ##0 ((sclk_o != CPOL[0]) != CPHA[0]);
   endsequence
   a_sel_onehot: assert property ($onehot0(~sel_n_o))
      else $error("more than one select low");
   a_sclk_idle: assert property (&sel_n_o |-> sclk_o == CPOL[0])
      else $error("serial clock off idle level");
   a_sel_lead: assert property (s_edge |-> sel_run_ff >= HALF - 1)
      else $error("select lead too short");
   a_sel_trail: assert property ($rose(&sel_n_o) |-> run_ff >= HALF - 1)
      else $error("select trail too short");
   a_half_period: assert property (s_edge |-> run_ff >= HALF - 1)
      else $error("serial clock half period too short");
   a_mosi_steady: assert property (s_sample |-> $stable(mosi_o))
      else $error("data out changed on sampling edge");
   a_sel_steady: assert property (s_edge |-> $stable(sel_n_o) && !(&sel_n_o))
      else $error("select moved during a byte");
   a_resp_hold: assert property (resp_valid_o && !resp_ready_i |=> resp_valid_o
      && $stable({resp_sel_o, resp_inst_o, resp_data_o}))
      else $error("response changed while held");
   a_no_dummy: assert property (resp_valid_o |-> resp_inst_o != 2'b11)
      else $error("dummy logged a response");
endmodule // smfc_sva

// [test/smfc_slave.sv]
// Behavioural slave device in any clock mode with a fixed reply byte
module smfc_slave
   import smfc_pkg::*;
#(
   parameter logic [7:0] REPLY = 8'ha5,
   parameter int CPOL = 0,
   parameter int CPHA = 0
) (
   // Serial bus from the master
   input wire logic sclk_i,
   input wire logic [15:0] sel_n_i,
   input wire logic mosi_i,
   // Reply line and last byte received
   output logic miso_o,
   output logic [7:0] rx_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] tx;
   logic [2:0] cnt;
   logic sel;
   logic sck;
   assign sel = ~&sel_n_i;
   // Folded clock: its rising edge is the sampling edge in every mode
   assign sck = sclk_i ^ CPOL[0] ^ CPHA[0];
   // Released line shows the inverse of the first reply bit
   assign miso_o = sel ? tx[7] : ~tx[7];
   initial begin
      tx = REPLY;
      cnt = 3'h0;
      rx_o = 8'h00;
   end
   always @(negedge sel) begin
      tx = REPLY;
      cnt = 3'h0;
   end
   always @(posedge sck) if (sel) begin
      rx_o = {rx_o[6:0], mosi_i};
      cnt = cnt + 3'h1;
   end
   always @(negedge sck) if (sel) tx = (cnt == 3'h0) ? REPLY : {tx[6:0], 1'b0};
endmodule // smfc_slave

// [test/smfc_top_tb.sv]
// Self-checking bench of the serial master controller
module smfc_top_tb
   import smfc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TP = 16;
   logic clock_i, rst_n_i, cmd_valid_i, cmd_ready_o, sclk_o, mosi_o, miso_i;
   logic resp_valid_o, resp_ready_i;
   logic [3:0] cmd_sel_i, resp_sel_o;
   logic [1:0] cmd_inst_i, resp_inst_o;
   logic [7:0] cmd_data_i, resp_data_o, rx;
   logic [15:0] sel_n_o;
   logic cmd_ready_m3, sclk_m3, mosi_m3, miso_m3, resp_valid_m3;
   logic [3:0] resp_sel_m3;
   logic [1:0] resp_inst_m3;
   logic [7:0] resp_data_m3, rx_m3;
   logic [15:0] sel_n_m3;
   int errors, n_tests;
   smfc_top #(.T_PERIOD(TP), .CMD_DEPTH(4), .cmd_queue_depth_bits(2), .RESP_DEPTH(2),
      .resp_queue_depth_bits(1)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .cmd_sel_i(cmd_sel_i), .cmd_inst_i(cmd_inst_i), .cmd_data_i(cmd_data_i),
      .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .sclk_o(sclk_o),
      .sel_n_o(sel_n_o), .mosi_o(mosi_o), .miso_i(miso_i), .resp_sel_o(resp_sel_o),
      .resp_inst_o(resp_inst_o), .resp_data_o(resp_data_o),
      .resp_valid_o(resp_valid_o), .resp_ready_i(resp_ready_i));
   smfc_slave slave_u (.sclk_i(sclk_o), .sel_n_i(sel_n_o), .mosi_i(mosi_o),
      .miso_o(miso_i), .rx_o(rx));
   // Second controller in mode 1/1 sharing the command and response handshakes
   smfc_top #(.T_PERIOD(TP), .CPOL(1), .CPHA(1), .CMD_DEPTH(4), .cmd_queue_depth_bits(2),
      .RESP_DEPTH(2), .resp_queue_depth_bits(1)) dut_m3_u (.clock_i(clock_i),
      .rst_n_i(rst_n_i), .cmd_sel_i(cmd_sel_i), .cmd_inst_i(cmd_inst_i),
      .cmd_data_i(cmd_data_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_m3),
      .sclk_o(sclk_m3), .sel_n_o(sel_n_m3), .mosi_o(mosi_m3), .miso_i(miso_m3),
      .resp_sel_o(resp_sel_m3), .resp_inst_o(resp_inst_m3), .resp_data_o(resp_data_m3),
      .resp_valid_o(resp_valid_m3), .resp_ready_i(resp_ready_i));
   smfc_slave #(.CPOL(1), .CPHA(1)) slave_m3_u (.sclk_i(sclk_m3), .sel_n_i(sel_n_m3),
      .mosi_i(mosi_m3), .miso_o(miso_m3), .rx_o(rx_m3));
   always #12.5 clock_i = ~clock_i;
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("compares %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task tick;
      @(posedge clock_i);
      #2;
   endtask
   task cut(input int k);
      if (k > 4000) begin
         errors++;
         $display("[ERR] %0t wait ran out", $time);
         final_report;
      end
   endtask
   task send(input logic [3:0] s, input logic [1:0] c, input logic [7:0] d);
      int k;
      tick;
      {cmd_sel_i, cmd_inst_i, cmd_data_i} = {s, c, d};
      cmd_valid_i = 1'b1;
      for (k = 0; cmd_ready_o !== 1'b1; k++) begin
         tick;
         cut(k);
      end
      tick;
      cmd_valid_i = 1'b0;
   endtask
   task take(input logic [3:0] s, input logic [1:0] c, input logic [7:0] d);
      int k;
      tick;
      for (k = 0; resp_valid_o !== 1'b1; k++) begin
         tick;
         cut(k);
      end
      chk({2'h0, resp_sel_o, resp_inst_o, resp_data_o}, {2'h0, s, c, d});
      chk({1'b0, resp_valid_m3, resp_sel_m3, resp_inst_m3, resp_data_m3}, {2'h1, s, c, d});
      resp_ready_i = 1'b1;
      tick;
      resp_ready_i = 1'b0;
   endtask
   task wait_sel(input logic busy);
      int k;
      for (k = 0; (sel_n_o !== SMFC_SEL_IDLE) !== busy; k++) begin
         tick;
         cut(k);
      end
   endtask
   task t_codes;
      send(4'h3, SMFC_WRITE, 8'h96);
      send(4'h3, SMFC_READ, 8'h77);
      send(4'h3, SMFC_DUPLEX, 8'h3c);
      send(4'h3, SMFC_DUMMY, 8'hff);
      take(4'h3, SMFC_WRITE, 8'h96);
      take(4'h3, SMFC_READ, 8'ha5);
      take(4'h3, SMFC_DUPLEX, 8'ha5);
      wait_sel(1'b0);
      chk({8'h00, rx}, 16'h003c);
      chk({8'h00, rx_m3}, 16'h003c);
      $display("codes test done");
   endtask
   task t_slaves;
      for (int i = 0; i < 16; i++) begin
         send(i[3:0], SMFC_WRITE, i[7:0]);
         send(i[3:0], SMFC_DUMMY, 8'h00);
         wait_sel(1'b1);
         chk(sel_n_o, ~(16'h0001 << i));
         chk(sel_n_m3, ~(16'h0001 << i));
         wait_sel(1'b0);
         chk(sel_n_o, SMFC_SEL_IDLE);
         take(i[3:0], SMFC_WRITE, i[7:0]);
      end
      $display("select test done");
   endtask
   task t_b2b;
      int gap;
      gap = 0;
      send(4'h5, SMFC_WRITE, 8'hc3);
      send(4'h5, SMFC_DUPLEX, 8'h5a);
      wait_sel(1'b1);
      repeat (2 * TP * 8) begin
         tick;
         if (sel_n_o !== 16'hffdf) gap++;
      end
      chk(gap[15:0], 16'h0000);
      send(4'h5, SMFC_DUMMY, 8'h00);
      take(4'h5, SMFC_WRITE, 8'hc3);
      take(4'h5, SMFC_DUPLEX, 8'ha5);
      chk({8'h00, rx}, 16'h005a);
      chk({8'h00, rx_m3}, 16'h005a);
      $display("back to back test done");
   endtask
   task t_fill;
      int n;
      logic r;
      n = 0;
      tick;
      {cmd_sel_i, cmd_inst_i, cmd_data_i} = {4'h1, SMFC_WRITE, 8'h00};
      cmd_valid_i = 1'b1;
      repeat (1200) begin
         r = cmd_ready_o;
         tick;
         if (r === 1'b1) begin
            n++;
            cmd_data_i = n[7:0];
         end
      end
      chk({14'h0000, cmd_ready_o, cmd_ready_m3}, 16'h0000);
      cmd_valid_i = 1'b0;
      for (int j = 0; j < n; j++) take(4'h1, SMFC_WRITE, j[7:0]);
      repeat (4 * TP * 10) tick;
      chk({15'h0000, resp_valid_o}, 16'h0000);
      $display("fill test done");
   endtask
   initial begin
      clock_i = 1'b0;
      rst_n_i = 1'b0;
      {cmd_sel_i, cmd_inst_i, cmd_data_i, cmd_valid_i, resp_ready_i} = 16'h0000;
      errors = 0;
      n_tests = 0;
      repeat (4) @(posedge clock_i);
      chk(sel_n_o, SMFC_SEL_IDLE);
      chk({15'h0000, sclk_o}, 16'h0000);
      chk({15'h0000, sclk_m3}, 16'h0001);
      #2;
      rst_n_i = 1'b1;
      tick;
      chk({15'h0000, cmd_ready_o}, 16'h0001);
      $display("reset test done");
      t_codes;
      t_slaves;
      t_b2b;
      t_fill;
      final_report;
   end
endmodule // smfc_top_tb
bind smfc_top smfc_sva #(.T_PERIOD(T_PERIOD), .CPOL(CPOL), .CPHA(CPHA)) sva_u (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_o(sclk_o), .sel_n_o(sel_n_o),
   .mosi_o(mosi_o), .resp_sel_o(resp_sel_o), .resp_inst_o(resp_inst_o),
   .resp_data_o(resp_data_o), .resp_valid_o(resp_valid_o), .resp_ready_i(resp_ready_i));
